// >>> uart_irq_consts.svh
// register offsets, field positions and codes of the interrupt and baud block
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

`define ADR_IDENT 4'h0
`define ADR_IEN 4'h1
`define ADR_DIV_LO 4'h2
`define ADR_DIV_HI 4'h3
`define ADR_SCRATCH 4'h4
`define ADR_LINE 4'h5
`define ADR_HAND 4'h6
`define ADR_CFG 4'h7
`define ADR_DATA 4'h8

`define IEN_MASK 8'h0f
`define IEN_RX 0
`define IEN_TX 1
`define IEN_LS 2
`define IEN_HS 3

`define FCR_FIFO_EN 0

`define CFG_HIGH_SPEED 0
`define CFG_PRE_LSB 1
`define CFG_PRE_MSB 2
`define CFG_IRQ_OE 3
`define CFG_MASK 8'h0f

`define CODE_NONE 4'h1
`define CODE_LS 4'h6
`define CODE_RX 4'h4
`define CODE_TIMEOUT 4'hc
`define CODE_TX 4'h2
`define CODE_HS 4'h0

`define PRE_MODULUS 5'h0d
`define PRE_STEP_13 5'h01
`define PRE_STEP_1625 5'h08
`define PRE_STEP_1 5'h0d

`define DIV_RESET 16'h000c
`define DIV_ONE 16'h0001

`endif

// >>> uart_irq_pkg.sv
// types shared by the interrupt and baud block
`default_nettype none
package uart_irq_pkg;
  typedef enum logic [1:0] {
    PRE_DIV_13 = 2'h0,
    PRE_DIV_1625 = 2'h1,
    PRE_DIV_1 = 2'h3
  } prediv_e;
  typedef logic [3:0] irq_code_t;
endpackage : uart_irq_pkg
`default_nettype wire

// >>> uart_irq_id_and_baud_gen.sv
// interrupt identification, enables, scratch and baud generator of the serial port
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "uart_irq_consts.svh"
`default_nettype none

module uart_irq_id_and_baud_gen #(
  parameter logic [15:0] DIV_INIT = `DIV_RESET
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic rx_timeout,
  input wire logic tx_empty_event,
  input wire logic overrun_event,
  input wire logic parity_error_event,
  input wire logic missing_stop_event,
  input wire logic silent_line_event,
  input wire logic cts_change_event,
  input wire logic dsr_change_event,
  input wire logic ring_trailing_edge_event,
  input wire logic dcd_change_event,
  input wire logic ref_tick,
  output logic baud16_tick,
  output logic fifo_mode,
  output logic rx_pop,
  output logic tx_push,
  output logic [7:0] tx_data,
  output logic irq_out,
  output logic irq_oe
);

  logic [3:0] interrupt_enable;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [7:0] scratch_pad;
  logic [7:0] config_bits;
  logic [3:0] line_flags;
  logic [3:0] hand_flags;
  logic tx_empty_flag;
  logic [4:0] pre_acc;
  logic [15:0] div_cnt;
  logic ref_pulse;

  logic [3:0] line_events;
  logic [3:0] hand_events;
  logic ls_pend;
  logic rx_pend;
  logic to_pend;
  logic tx_pend;
  logic hs_pend;
  logic any_pend;
  uart_irq_pkg::irq_code_t code;
  logic [7:0] ident;
  logic rd_ident;
  logic rd_line;
  logic rd_hand;
  logic wr_data_port;
  logic [4:0] pre_step;
  logic [5:0] next_pre_acc;
  logic next_ref_pulse;
  logic [15:0] divisor;

  // highest pending source wins
  function automatic uart_irq_pkg::irq_code_t pick_code(
    input logic ls,
    input logic rx,
    input logic to,
    input logic tx,
    input logic hs
  );
    uart_irq_pkg::irq_code_t c;
    c = `CODE_NONE;
    if (ls) begin
      c = `CODE_LS;
    end else if (rx) begin
      c = `CODE_RX;
    end else if (to) begin
      c = `CODE_TIMEOUT;
    end else if (tx) begin
      c = `CODE_TX;
    end else if (hs) begin
      c = `CODE_HS;
    end
    return c;
  endfunction : pick_code

  assign line_events = {silent_line_event, missing_stop_event, parity_error_event, overrun_event};
  assign hand_events = {dcd_change_event, ring_trailing_edge_event, dsr_change_event, cts_change_event};
  assign rd_ident = rd_stb && (addr == `ADR_IDENT);
  assign rd_line = rd_stb && (addr == `ADR_LINE);
  assign rd_hand = rd_stb && (addr == `ADR_HAND);
  assign wr_data_port = wr_stb && (addr == `ADR_DATA);

  assign ls_pend = interrupt_enable[`IEN_LS] && (|line_flags);
  assign rx_pend = interrupt_enable[`IEN_RX] && rx_ready;
  assign to_pend = interrupt_enable[`IEN_RX] && fifo_mode && rx_timeout;
  assign tx_pend = interrupt_enable[`IEN_TX] && tx_empty_flag;
  assign hs_pend = interrupt_enable[`IEN_HS] && (|hand_flags);
  assign any_pend = ls_pend || rx_pend || to_pend || tx_pend || hs_pend;
  assign code = pick_code(ls_pend, rx_pend, to_pend, tx_pend, hs_pend);
  assign ident = {fifo_mode, fifo_mode, 2'h0, code};

  // host writes to control registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable <= 4'h0;
      scratch_pad <= 8'h00;
      config_bits <= 8'h00;
      fifo_mode <= 1'b0;
    end else if (wr_stb) begin
      case (addr)
        `ADR_IDENT: begin
          fifo_mode <= wr_data[`FCR_FIFO_EN];
        end
        `ADR_IEN: begin
          interrupt_enable <= wr_data[3:0];
        end
        `ADR_SCRATCH: begin
          scratch_pad <= wr_data;
        end
        `ADR_CFG: begin
          config_bits <= wr_data & `CFG_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // divisor bytes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_divisor_low <= DIV_INIT[7:0];
      baud_divisor_high <= DIV_INIT[15:8];
    end else if (wr_stb && (addr == `ADR_DIV_LO)) begin
      baud_divisor_low <= wr_data;
    end else if (wr_stb && (addr == `ADR_DIV_HI)) begin
      baud_divisor_high <= wr_data;
    end
  end

  // sticky line error flags, a new event beats the clearing read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_flags <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (line_events[i]) begin
          line_flags[i] <= 1'b1;
        end else if (rd_line) begin
          line_flags[i] <= 1'b0;
        end
      end
    end
  end

  // sticky handshake change flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hand_flags <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (hand_events[i]) begin
          hand_flags[i] <= 1'b1;
        end else if (rd_hand) begin
          hand_flags[i] <= 1'b0;
        end
      end
    end
  end

  // transmit empty flag
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_empty_flag <= 1'b0;
    end else if (tx_empty_event) begin
      tx_empty_flag <= 1'b1;
    end else if (wr_data_port || (rd_ident && (code == `CODE_TX))) begin
      tx_empty_flag <= 1'b0;
    end
  end

  // data port strobes toward the shifters and fifos
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      rx_pop <= rd_stb && (addr == `ADR_DATA);
      tx_push <= wr_data_port;
      if (wr_data_port) begin
        tx_data <= wr_data;
      end
    end
  end

  // read data, valid in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `ADR_IDENT: rd_data <= ident;
        `ADR_IEN: rd_data <= {4'h0, interrupt_enable};
        `ADR_DIV_LO: rd_data <= baud_divisor_low;
        `ADR_DIV_HI: rd_data <= baud_divisor_high;
        `ADR_SCRATCH: rd_data <= scratch_pad;
        `ADR_LINE: rd_data <= {3'h0, line_flags, 1'b0};
        `ADR_HAND: rd_data <= {4'h0, hand_flags};
        `ADR_CFG: rd_data <= config_bits;
        `ADR_DATA: rd_data <= rx_data;
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // interrupt pin
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_out <= any_pend;
      irq_oe <= config_bits[`CFG_IRQ_OE];
    end
  end

  // fractional pre-divider: step/13 of the input ticks pass
  always_comb begin
    pre_step = `PRE_STEP_1;
    if (!config_bits[`CFG_HIGH_SPEED]) begin
      case (uart_irq_pkg::prediv_e'(config_bits[`CFG_PRE_MSB:`CFG_PRE_LSB]))
        uart_irq_pkg::PRE_DIV_13: pre_step = `PRE_STEP_13;
        uart_irq_pkg::PRE_DIV_1625: pre_step = `PRE_STEP_1625;
        default: pre_step = `PRE_STEP_1;
      endcase
    end
    next_pre_acc = {1'b0, pre_acc} + {1'b0, pre_step};
    next_ref_pulse = 1'b0;
    if (ref_tick && (next_pre_acc >= {1'b0, `PRE_MODULUS})) begin
      next_pre_acc = next_pre_acc - {1'b0, `PRE_MODULUS};
      next_ref_pulse = 1'b1;
    end
    if (!ref_tick) begin
      next_pre_acc = {1'b0, pre_acc};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_acc <= 5'h00;
      ref_pulse <= 1'b0;
    end else begin
      pre_acc <= next_pre_acc[4:0];
      ref_pulse <= next_ref_pulse;
    end
  end

  // divisor zero behaves as one
  assign divisor = ({baud_divisor_high, baud_divisor_low} == 16'h0000) ? `DIV_ONE
                   : {baud_divisor_high, baud_divisor_low};

  // sixteen-times sampling tick for transmitter and receiver
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= `DIV_ONE;
      baud16_tick <= 1'b0;
    end else if (ref_pulse) begin
      if (div_cnt <= `DIV_ONE) begin
        div_cnt <= divisor;
        baud16_tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt - `DIV_ONE;
        baud16_tick <= 1'b0;
      end
    end else begin
      baud16_tick <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence scratch_write;
    wr_stb && (addr == `ADR_SCRATCH);
  endsequence

  sequence scratch_read;
    rd_stb && (addr == `ADR_SCRATCH);
  endsequence

  chk_upper_bits: assert property (
    rd_ident |=> rd_data[7:6] == {2{$past(fifo_mode)}})
    else $error("ident upper bits do not follow fifo mode");

  chk_zero_bits: assert property (
    rd_ident |=> rd_data[5:4] == 2'h0)
    else $error("ident bits 5:4 not zero");

  chk_timeout_bit: assert property (
    rd_ident && !fifo_mode |=> !rd_data[3])
    else $error("ident bit 3 set outside fifo mode");

  chk_none_pending: assert property (
    rd_ident && !any_pend |=> rd_data[3:0] == `CODE_NONE)
    else $error("idle ident not 0001");

  chk_line_first: assert property (
    rd_ident && ls_pend |=> rd_data[3:0] == `CODE_LS)
    else $error("line error not reported first");

  chk_rx_second: assert property (
    rd_ident && rx_pend && !ls_pend |=> rd_data[3:0] == `CODE_RX)
    else $error("receive ready code wrong");

  chk_tx_write_clear: assert property (
    wr_data_port && !tx_empty_event |=> !tx_empty_flag && tx_push)
    else $error("transmit empty flag not cleared by write");

  chk_hs_last: assert property (
    rd_ident && (code == `CODE_HS) |-> hs_pend && !tx_pend && !rx_pend && !ls_pend && !to_pend)
    else $error("handshake code with higher source pending");

  chk_ien_upper: assert property (
    rd_stb && (addr == `ADR_IEN) |=> rd_data[7:4] == 4'h0)
    else $error("enable bits 7:4 not zero");

  chk_all_masked: assert property (
    interrupt_enable == 4'h0 |=> !irq_out)
    else $error("interrupt with all sources disabled");

  chk_scratch_echo: assert property (
    scratch_write ##1 scratch_read |=> rd_data == $past(wr_data, 2))
    else $error("scratch value not returned");

  chk_pin_enable: assert property (
    irq_oe |-> $past(config_bits[`CFG_IRQ_OE]))
    else $error("interrupt pin driven while disabled");

  chk_line_clear: assert property (
    rd_line && (line_events == 4'h0) |=> line_flags == 4'h0)
    else $error("line flags not cleared by read");

  chk_tick_width: assert property (
    baud16_tick |=> !baud16_tick || $past(ref_pulse))
    else $error("sampling tick without reference pulse");

endmodule : uart_irq_id_and_baud_gen
`default_nettype wire

// >>> uart_peer_model.sv
// far side model: receive fifo level, popped byte and reference tick
`default_nettype none
module uart_peer_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ref_run,
  input wire logic load,
  input wire logic [7:0] load_byte,
  input wire logic rx_pop,
  output logic rx_ready,
  output logic [7:0] rx_data,
  output logic ref_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ready <= 1'b0;
      rx_data <= 8'h00;
    end else if (load) begin
      rx_ready <= 1'b1;
      rx_data <= load_byte;
    end else if (rx_pop) begin
      rx_ready <= 1'b0;
      // popped slot no longer shows the old byte
      rx_data <= ~rx_data;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= ref_run;
    end
  end
endmodule : uart_peer_model
`default_nettype wire

// >>> tb_uart_irq_id_and_baud_gen.sv
// self-checking bench of the interrupt and baud block
`include "uart_irq_consts.svh"
`default_nettype none
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); fail_count++; end end
module tb_uart_irq_id_and_baud_gen;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, arst_n, wr_stb, rd_stb, rx_timeout, ref_run, load, rx_ready, ref_tick;
  logic rx_pop, tx_push, baud16_tick, fifo_mode, irq_out, irq_oe;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, rx_data, load_byte, tx_data, seed;
  logic [8:0] ev;
  int fail_count, num_checks, cycles;

  uart_irq_id_and_baud_gen #(.DIV_INIT(16'h000c)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .rx_data(rx_data), .rx_ready(rx_ready),
    .rx_timeout(rx_timeout), .tx_empty_event(ev[0]), .overrun_event(ev[1]),
    .parity_error_event(ev[2]), .missing_stop_event(ev[3]), .silent_line_event(ev[4]),
    .cts_change_event(ev[5]), .dsr_change_event(ev[6]), .ring_trailing_edge_event(ev[7]),
    .dcd_change_event(ev[8]), .ref_tick(ref_tick), .baud16_tick(baud16_tick),
    .fifo_mode(fifo_mode), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data),
    .irq_out(irq_out), .irq_oe(irq_oe));

  uart_peer_model peer (
    .sys_clk(sys_clk), .arst_n(arst_n), .ref_run(ref_run), .load(load), .load_byte(load_byte),
    .rx_pop(rx_pop), .rx_ready(rx_ready), .rx_data(rx_data), .ref_tick(ref_tick));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic int exp_ticks(input int refs, input int step, input int dv);
    return refs * step / (13 * dv);
  endfunction : exp_ticks

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] ex, input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    `CHECK(nm, ex, rd_data)
  endtask : rdchk

  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev <= 9'h001 << i;
    @(posedge sys_clk);
    ev <= 9'h000;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  task automatic baud(input logic [7:0] cfg, input logic [15:0] dv, input int step);
    int refs;
    int ticks;
    int ex;
    wr(`ADR_CFG, cfg);
    wr(`ADR_DIV_LO, dv[7:0]);
    wr(`ADR_DIV_HI, dv[15:8]);
    refs = 0;
    ticks = 0;
    ref_run <= 1'b1;
    repeat (400) begin
      @(posedge sys_clk);
      #1;
      refs += int'(ref_tick);
      ticks += int'(baud16_tick);
    end
    @(posedge sys_clk);
    ref_run <= 1'b0;
    ex = exp_ticks(refs, step, int'(dv));
    `CHECK("baud ticks", 1'b1, (ticks >= ex - 2) && (ticks <= ex + 2))
  endtask : baud

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    {arst_n, wr_stb, rd_stb, rx_timeout, ref_run, load} = '0;
    {addr, wr_data, load_byte, ev} = '0;
    seed = 8'h49;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdchk(`ADR_IDENT, 8'h01, "ident");
    rdchk(`ADR_IEN, 8'h00, "enable");
    rdchk(`ADR_DIV_LO, 8'h0c, "div low");
    rdchk(`ADR_DIV_HI, 8'h00, "div high");
    rdchk(`ADR_SCRATCH, 8'h00, "scratch");
    rdchk(4'h9, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(`ADR_IEN, seed);
      rdchk(`ADR_IEN, seed & 8'h0f, "enable");
      wr(`ADR_SCRATCH, ~seed);
      rdchk(`ADR_SCRATCH, ~seed, "scratch");
      wr(`ADR_DIV_HI, seed);
      rdchk(`ADR_DIV_HI, seed, "div high");
    end
    // write then read back to back
    @(posedge sys_clk);
    addr <= `ADR_SCRATCH;
    wr_data <= seed;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    `CHECK("scratch b2b", seed, rd_data)
    wr(`ADR_IEN, 8'h00);
    pulse(1);
    pulse(5);
    pulse(0);
    rdchk(`ADR_IDENT, 8'h01, "ident");
    `CHECK("irq", 1'b0, irq_out)
    wr(`ADR_IEN, 8'h0f);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHECK("irq", 1'b1, irq_out)
    rdchk(`ADR_IDENT, 8'h06, "ident");
    rdchk(`ADR_LINE, 8'h02, "line");
    rdchk(`ADR_IDENT, 8'h02, "ident");
    rdchk(`ADR_IDENT, 8'h00, "ident");
    rdchk(`ADR_HAND, 8'h01, "hand");
    rdchk(`ADR_IDENT, 8'h01, "ident");
    for (int i = 1; i < 5; i++) begin
      pulse(i);
      rdchk(`ADR_IDENT, 8'h06, "ident");
      rdchk(`ADR_LINE, 8'h01 << i, "line");
    end
    for (int i = 0; i < 4; i++) begin
      pulse(5 + i);
      rdchk(`ADR_IDENT, 8'h00, "ident");
      rdchk(`ADR_HAND, 8'h01 << i, "hand");
    end
    pulse(0);
    rdchk(`ADR_IDENT, 8'h02, "ident");
    pulse(0);
    wr(`ADR_DATA, seed);
    #1;
    `CHECK("tx push", 1'b1, tx_push)
    `CHECK("tx data", seed, tx_data)
    rdchk(`ADR_IDENT, 8'h01, "ident");
    seed = lfsr(seed);
    @(posedge sys_clk);
    load <= 1'b1;
    load_byte <= seed;
    @(posedge sys_clk);
    load <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rdchk(`ADR_IDENT, 8'h04, "ident");
    `CHECK("irq", 1'b1, irq_out)
    rdchk(`ADR_DATA, seed, "rx data");
    `CHECK("rx pop", 1'b1, rx_pop)
    @(posedge sys_clk);
    #1;
    `CHECK("rd idle", 8'h00, rd_data)
    `CHECK("rx pop", 1'b0, rx_pop)
    @(posedge sys_clk);
    rdchk(`ADR_IDENT, 8'h01, "ident");
    wr(`ADR_IDENT, 8'h01);
    rdchk(`ADR_IDENT, 8'hc1, "ident");
    `CHECK("fifo mode", 1'b1, fifo_mode)
    @(posedge sys_clk);
    rx_timeout <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk(`ADR_IDENT, 8'hcc, "ident");
    @(posedge sys_clk);
    rx_timeout <= 1'b0;
    pulse(1);
    rdchk(`ADR_IDENT, 8'hc6, "ident");
    rdchk(`ADR_LINE, 8'h02, "line");
    wr(`ADR_IDENT, 8'h00);
    rdchk(`ADR_IDENT, 8'h01, "ident");
    wr(`ADR_CFG, 8'h08);
    @(posedge sys_clk);
    #1;
    `CHECK("irq oe", 1'b1, irq_oe)
    baud(8'h01, 16'h0001, 13);
    `CHECK("irq oe", 1'b0, irq_oe)
    baud(8'h00, 16'h0002, 1);
    baud(8'h02, 16'h0003, 8);
    baud(8'h04, 16'h0005, 13);
    baud(8'h06, 16'h0004, 13);
    finish_test();
  end
endmodule : tb_uart_irq_id_and_baud_gen
`default_nettype wire
